// ### cpuag_pkg.sv
`default_nettype none
package cpuag_pkg;
  localparam int          ADDR_W       = 14;
  localparam logic [13:0] PC_RESET     = 14'h3FFD;
  localparam logic [13:0] SHADOW_RESET = 14'h3FFD;
  localparam logic [7:0]  ACC_RESET    = 8'h00;
  localparam logic [7:0]  PTR_RESET    = 8'h00;
  localparam logic [1:0]  FLAGS_RESET  = 2'h0;
  localparam int          FLAG_NIL     = 1;
  localparam int          FLAG_BORROW  = 0;
  localparam logic [13:0] WINDOW_ADDR  = 14'h000E;
  localparam logic [13:0] POINTER_ADDR = 14'h000F;
  // single-byte opcodes
  localparam logic [7:0]  OPC_LOAD_IMM = 8'hA6;
  localparam logic [7:0]  OPC_LOAD_DIR = 8'hB6;
  localparam logic [7:0]  OPC_STORE_DIR = 8'hB7;
  localparam logic [7:0]  OPC_CLEAR_DIR = 8'h3F;
  localparam logic [7:0]  OPC_GOTO     = 8'hBC;
  localparam logic [7:0]  OPC_CALL     = 8'hBD;
  localparam logic [7:0]  OPC_BRSUB    = 8'hAD;
  localparam logic [7:0]  OPC_RET      = 8'hBE;
  localparam logic [7:0]  OPC_CMP_IMM  = 8'hA1;
  localparam logic [7:0]  OPC_CMP_DIR  = 8'hB1;
  localparam logic [7:0]  OPC_SBC_IMM  = 8'hA2;
  localparam logic [7:0]  OPC_SBC_DIR  = 8'hB2;
  localparam logic [7:0]  OPC_INC_DIR  = 8'h3C;
  localparam logic [7:0]  OPC_DEC_DIR  = 8'h3A;
  localparam logic [7:0]  OPC_MOVE_DD  = 8'h4E;
  localparam logic [7:0]  OPC_MOVE_IMD = 8'h3E;
  localparam logic [7:0]  OPC_CLC      = 8'h38;
  localparam logic [7:0]  OPC_SEC      = 8'h39;
  // conditional branches: 0x60+{sense,flag}
  localparam logic [5:0]  OPC_BRANCH_HI = 6'h18;
  // opcode groups carrying an embedded address
  localparam logic [2:0]  SRT_CLEAR_HI = 3'h4;
  localparam logic [2:0]  SRT_LOAD_HI  = 3'h6;
  localparam logic [2:0]  SRT_STORE_HI = 3'h7;
  localparam logic [3:0]  TNY_INC_HI   = 4'h2;
  localparam logic [3:0]  TNY_DEC_HI   = 4'h5;

  typedef enum logic [3:0] {
    MODE_INH, MODE_IMM, MODE_DIR, MODE_SRT, MODE_TNY,
    MODE_EXT, MODE_REL, MODE_IMD, MODE_DD
  } cpuag_mode_t;

  typedef enum logic [3:0] {
    OP_NOP, OP_LOAD, OP_STORE, OP_CLEAR, OP_GOTO, OP_CALL, OP_BRSUB,
    OP_RET, OP_CMP, OP_SBC, OP_INC, OP_DEC, OP_MOVE, OP_CLC, OP_SEC,
    OP_BRANCH
  } cpuag_op_t;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_OP1   = 3'b001,
    ST_OP2   = 3'b011,
    ST_EXEC  = 3'b010,
    ST_WRITE = 3'b110
  } cpuag_state_t;
endpackage
`default_nettype wire

// ### cpuag_addr_if.sv
`default_nettype none
interface cpuag_addr_if;
  import cpuag_pkg::*;
  cpuag_mode_t mode;
  logic [7:0]  opcode;
  logic [7:0]  op1;
  logic [7:0]  op2;
  logic [13:0] pc;
  logic [13:0] ea;
  logic [13:0] ea_dst;
  modport gen  (input mode, opcode, op1, op2, pc, output ea, ea_dst);
  modport user (output mode, opcode, op1, op2, pc, input ea, ea_dst);
endinterface
`default_nettype wire

// ### cpuag_addr_unit.sv
`default_nettype none
module cpuag_addr_unit
  import cpuag_pkg::*;
(
  cpuag_addr_if.gen ai
);
  always_comb begin
    ai.ea_dst = {6'h00, ai.op2};
    unique case (ai.mode)
      MODE_SRT: ai.ea = {9'h000, ai.opcode[4:0]};
      MODE_TNY: ai.ea = {10'h000, ai.opcode[3:0]};
      MODE_DIR,
      MODE_DD:  ai.ea = {6'h00, ai.op1};
      // top two bits of the high byte dropped
      MODE_EXT: ai.ea = {ai.op1[5:0], ai.op2};
      // pc already points past the offset byte
      MODE_REL: ai.ea = ai.pc + {{6{ai.op1[7]}}, ai.op1};
      MODE_INH,
      MODE_IMM,
      MODE_IMD: ai.ea = {6'h00, ai.op2};
      default:  ai.ea = {6'h00, ai.op1};
    endcase
  end
endmodule
`default_nettype wire

// ### cpuag_core.sv
`default_nettype none
module cpuag_core
  import cpuag_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  output logic [13:0]      mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        dbg_flags_wr,
  input  wire logic [1:0]  dbg_flags_wdata,
  output logic [1:0]       dbg_flags_rdata,
  output logic [7:0]       acc_value,
  output logic [13:0]      pc_value
);
  cpuag_state_t state_reg;
  cpuag_state_t state_next;
  logic [13:0]  pc_reg;
  logic [13:0]  shadow_reg;
  logic [7:0]   acc_reg;
  logic [7:0]   pointer_reg;
  logic [1:0]   status_flags_reg;
  logic [7:0]   opcode_reg;
  logic [7:0]   op1_reg;
  logic [7:0]   op2_reg;
  logic [7:0]   tmp_reg;
  cpuag_mode_t  mode_now;
  cpuag_op_t    op_now;
  logic [13:0]  acc_addr;
  logic         acc_rd;
  logic         acc_wr;
  logic         data_acc;
  logic [7:0]   acc_wdata;
  logic [7:0]   rd_data;
  logic [7:0]   operand;
  logic [8:0]   diff9;
  logic         to_pointer;
  logic         take_branch;

  cpuag_addr_if ai ();

  function automatic cpuag_op_t op_of(input logic [7:0] opc);
    cpuag_op_t r;
    r = OP_NOP;
    // short forms exist only for the three ops below
    if (opc[7:5] == SRT_CLEAR_HI)
      r = OP_CLEAR;
    else if (opc[7:5] == SRT_LOAD_HI || opc[7:5] == 3'h6 + 3'h0)
      r = OP_LOAD;
    else if (opc[7:5] == SRT_STORE_HI)
      r = OP_STORE;
    else if (opc[7:4] == TNY_INC_HI)
      r = OP_INC;
    else if (opc[7:4] == TNY_DEC_HI)
      r = OP_DEC;
    else if (opc[7:2] == OPC_BRANCH_HI)
      r = OP_BRANCH;
    else begin
      unique case (opc)
        OPC_LOAD_IMM,
        OPC_LOAD_DIR:  r = OP_LOAD;
        OPC_STORE_DIR: r = OP_STORE;
        OPC_CLEAR_DIR: r = OP_CLEAR;
        OPC_GOTO:      r = OP_GOTO;
        OPC_CALL:      r = OP_CALL;
        OPC_BRSUB:     r = OP_BRSUB;
        OPC_RET:       r = OP_RET;
        OPC_CMP_IMM,
        OPC_CMP_DIR:   r = OP_CMP;
        OPC_SBC_IMM,
        OPC_SBC_DIR:   r = OP_SBC;
        OPC_INC_DIR:   r = OP_INC;
        OPC_DEC_DIR:   r = OP_DEC;
        OPC_MOVE_DD,
        OPC_MOVE_IMD:  r = OP_MOVE;
        OPC_CLC:       r = OP_CLC;
        OPC_SEC:       r = OP_SEC;
        default:       r = OP_NOP;
      endcase
    end
    return r;
  endfunction

  function automatic cpuag_mode_t mode_of(input logic [7:0] opc);
    cpuag_mode_t m;
    m = MODE_INH;
    if (opc[7:6] == 2'h2 && opc[5] == 1'b0 && opc[4:0] != 5'h00)
      m = MODE_INH;
    if (opc[7:5] == SRT_CLEAR_HI ||
        opc[7:5] == SRT_LOAD_HI || opc[7:5] == SRT_STORE_HI)
      m = MODE_SRT;
    else if (opc[7:4] == TNY_INC_HI || opc[7:4] == TNY_DEC_HI)
      m = MODE_TNY;
    else if (opc[7:2] == OPC_BRANCH_HI || opc == OPC_BRSUB)
      m = MODE_REL;
    else if (opc == OPC_GOTO || opc == OPC_CALL)
      m = MODE_EXT;
    else if (opc == OPC_LOAD_IMM || opc == OPC_CMP_IMM ||
             opc == OPC_SBC_IMM)
      m = MODE_IMM;
    else if (opc == OPC_MOVE_IMD)
      m = MODE_IMD;
    else if (opc == OPC_MOVE_DD)
      m = MODE_DD;
    else if (opc == OPC_LOAD_DIR || opc == OPC_STORE_DIR ||
             opc == OPC_CLEAR_DIR || opc == OPC_CMP_DIR ||
             opc == OPC_SBC_DIR || opc == OPC_INC_DIR ||
             opc == OPC_DEC_DIR)
      m = MODE_DIR;
    return m;
  endfunction

  function automatic logic needs_op1(input cpuag_mode_t m);
    return m != MODE_INH && m != MODE_SRT && m != MODE_TNY;
  endfunction

  function automatic logic needs_op2(input cpuag_mode_t m);
    return m == MODE_EXT || m == MODE_IMD || m == MODE_DD;
  endfunction

  // window redirect makes indexing work in every data mode
  function automatic logic [13:0] phys(input logic [13:0] ea,
                                       input logic [7:0]  ptr);
    return (ea == WINDOW_ADDR) ? {6'h00, ptr} : ea;
  endfunction

  assign mode_now  = mode_of(opcode_reg);
  assign op_now    = op_of(opcode_reg);
  assign ai.mode   = mode_now;
  assign ai.opcode = opcode_reg;
  assign ai.op1    = op1_reg;
  assign ai.op2    = op2_reg;
  assign ai.pc     = pc_reg;

  cpuag_addr_unit u_addr (
    .ai (ai)
  );

  // one memory access per cycle
  always_comb begin
    acc_addr  = pc_reg;
    acc_rd    = 1'b0;
    acc_wr    = 1'b0;
    data_acc  = 1'b0;
    acc_wdata = 8'h00;
    unique case (state_reg)
      ST_FETCH,
      ST_OP1,
      ST_OP2: begin
        acc_rd = 1'b1;
      end
      ST_EXEC: begin
        unique case (op_now)
          OP_LOAD,
          OP_CMP,
          OP_SBC: begin
            acc_addr = ai.ea;
            data_acc = 1'b1;
            acc_rd   = (mode_now != MODE_IMM);
          end
          OP_INC,
          OP_DEC: begin
            acc_addr = ai.ea;
            data_acc = 1'b1;
            acc_rd   = 1'b1;
          end
          OP_STORE: begin
            acc_addr  = ai.ea;
            data_acc  = 1'b1;
            acc_wr    = 1'b1;
            acc_wdata = acc_reg;
          end
          OP_CLEAR: begin
            acc_addr = ai.ea;
            data_acc = 1'b1;
            acc_wr   = 1'b1;
          end
          OP_MOVE: begin
            data_acc = 1'b1;
            if (mode_now == MODE_IMD) begin
              acc_addr  = ai.ea_dst;
              acc_wr    = 1'b1;
              acc_wdata = op1_reg;
            end else begin
              acc_addr = ai.ea;
              acc_rd   = 1'b1;
            end
          end
          default: begin
            acc_addr = pc_reg;
          end
        endcase
      end
      ST_WRITE: begin
        data_acc  = 1'b1;
        acc_wr    = 1'b1;
        acc_wdata = tmp_reg;
        acc_addr  = (op_now == OP_MOVE) ? ai.ea_dst : ai.ea;
      end
      default: begin
        acc_rd = 1'b0;
      end
    endcase
  end

  // the pointer lives here, so direct accesses to its address raise no bus strobe
  assign to_pointer = data_acc && (acc_addr == POINTER_ADDR);
  assign mem_addr   = data_acc ? phys(acc_addr, pointer_reg) : acc_addr;
  assign mem_rd     = acc_rd && !to_pointer;
  assign mem_wr     = acc_wr && !to_pointer;
  assign mem_wdata  = acc_wdata;
  assign rd_data    = to_pointer ? pointer_reg : mem_rdata;
  assign operand    = (mode_now == MODE_IMM) ? op1_reg : rd_data;
  assign diff9      = {1'b0, acc_reg} - {1'b0, operand}
                      - {8'h00, (op_now == OP_SBC) &&
                                status_flags_reg[FLAG_BORROW]};
  // opcode bit 1 is the sense, bit 0 picks the flag
  assign take_branch = (status_flags_reg[opcode_reg[0]] ==
                        opcode_reg[1]);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_FETCH: state_next = needs_op1(mode_of(mem_rdata)) ? ST_OP1
                                                           : ST_EXEC;
      ST_OP1:   state_next = needs_op2(mode_now) ? ST_OP2 : ST_EXEC;
      ST_OP2:   state_next = ST_EXEC;
      ST_EXEC:  state_next = (op_now == OP_INC || op_now == OP_DEC ||
                              (op_now == OP_MOVE && mode_now == MODE_DD))
                             ? ST_WRITE : ST_FETCH;
      ST_WRITE: state_next = ST_FETCH;
      default:  state_next = ST_FETCH;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) state_reg <= ST_FETCH;
    else     state_reg <= state_next;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      opcode_reg <= 8'h00;
      op1_reg    <= 8'h00;
      op2_reg    <= 8'h00;
    end else begin
      if (state_reg == ST_FETCH) opcode_reg <= mem_rdata;
      if (state_reg == ST_OP1)   op1_reg    <= mem_rdata;
      if (state_reg == ST_OP2)   op2_reg    <= mem_rdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pc_reg <= PC_RESET;
    end else if (state_reg == ST_FETCH || state_reg == ST_OP1 ||
                 state_reg == ST_OP2) begin
      pc_reg <= pc_reg + 14'h0001;
    end else if (state_reg == ST_EXEC) begin
      unique case (op_now)
        OP_GOTO,
        OP_CALL,
        OP_BRSUB:  pc_reg <= ai.ea;
        OP_RET:    pc_reg <= shadow_reg;
        OP_BRANCH: if (take_branch) pc_reg <= ai.ea;
        default:   pc_reg <= pc_reg;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) shadow_reg <= SHADOW_RESET;
    else if (state_reg == ST_EXEC &&
             (op_now == OP_CALL || op_now == OP_BRSUB))
      shadow_reg <= pc_reg;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      acc_reg <= ACC_RESET;
    end else if (state_reg == ST_EXEC) begin
      if (op_now == OP_LOAD)     acc_reg <= operand;
      else if (op_now == OP_SBC) acc_reg <= diff9[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) tmp_reg <= 8'h00;
    else if (state_reg == ST_EXEC) begin
      if (op_now == OP_INC)      tmp_reg <= rd_data + 8'h01;
      else if (op_now == OP_DEC) tmp_reg <= rd_data - 8'h01;
      else                       tmp_reg <= rd_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) pointer_reg <= PTR_RESET;
    else if (acc_wr && to_pointer) pointer_reg <= acc_wdata;
  end

  // instruction results beat a debug write in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      status_flags_reg <= FLAGS_RESET;
    end else if (state_reg == ST_EXEC) begin
      unique case (op_now)
        OP_LOAD: status_flags_reg[FLAG_NIL] <= (operand == 8'h00);
        OP_STORE: status_flags_reg[FLAG_NIL] <= (acc_reg == 8'h00);
        OP_CLEAR: status_flags_reg[FLAG_NIL] <= 1'b1;
        OP_CMP,
        OP_SBC: begin
          status_flags_reg[FLAG_NIL]    <= (diff9[7:0] == 8'h00);
          status_flags_reg[FLAG_BORROW] <= diff9[8];
        end
        OP_MOVE: status_flags_reg[FLAG_NIL] <=
                   ((mode_now == MODE_IMD ? op1_reg : rd_data) == 8'h00);
        OP_CLC: status_flags_reg[FLAG_BORROW] <= 1'b0;
        OP_SEC: status_flags_reg[FLAG_BORROW] <= 1'b1;
        default: begin
          if (dbg_flags_wr) status_flags_reg <= dbg_flags_wdata;
        end
      endcase
    end else if (state_reg == ST_WRITE && op_now != OP_MOVE) begin
      status_flags_reg[FLAG_NIL] <= (tmp_reg == 8'h00);
    end else if (dbg_flags_wr) begin
      status_flags_reg <= dbg_flags_wdata;
    end
  end

  // flags leave only through the debug port, never the data bus
  assign dbg_flags_rdata = status_flags_reg;
  assign acc_value       = acc_reg;
  assign pc_value        = pc_reg;
endmodule
`default_nettype wire

// ### cpuag_mem_model.sv
`default_nettype none
module cpuag_mem_model (
  input  wire logic        clock,
  input  wire logic [13:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [0:16383];
  logic [21:0] wr_log [$];
  logic [7:0]  junk_reg = 8'h5A;
  // zero-wait async read; junk when idle so nothing leans on stale data
  always_comb mem_rdata = mem_rd ? mem[mem_addr] : junk_reg;
  always @(posedge clock) begin
    junk_reg <= ~junk_reg;
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
      wr_log.push_back({mem_addr, mem_wdata});
    end
  end
endmodule
`default_nettype wire

// ### cpuag_core_chk.sv
`default_nettype none
module cpuag_core_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [13:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  mem_rdata,
  input wire logic        dbg_flags_wr,
  input wire logic [1:0]  dbg_flags_wdata,
  input wire logic [1:0]  dbg_flags_rdata,
  input wire logic [7:0]  acc_value,
  input wire logic [13:0] pc_value
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence fetch_next;
    ##1 (mem_rd && !mem_wr);
  endsequence
  sequence write_then_fetch;
    mem_wr ##0 fetch_next;
  endsequence
  reset_vals_a: assert property (disable iff (1'b0) rst |=>
    pc_value == 14'h3FFD && acc_value == 8'h00 && dbg_flags_rdata == 2'h0)
    else $error("reset values wrong");
  first_fetch_a: assert property ($fell(rst) |->
    mem_rd && mem_addr == 14'h3FFD) else $error("first fetch wrong");
  strobe_excl_a: assert property (!(mem_rd && mem_wr))
    else $error("read and write together");
  wr_page_a: assert property (mem_wr |->
    mem_addr[13:8] == 6'h00 && mem_addr != 14'h000F)
    else $error("write outside direct page");
  rd_page_a: assert property (mem_rd && mem_addr != pc_value |->
    mem_addr[13:8] == 6'h00 && mem_addr != 14'h000F)
    else $error("data read outside direct page");
  pc_step_a: assert property (mem_rd && mem_addr == pc_value &&
    pc_value[13:8] != 6'h00 |=> pc_value == $past(pc_value) + 14'h0001)
    else $error("pc did not advance after fetch");
  wr_fetch_a: assert property (mem_wr |-> write_then_fetch)
    else $error("no fetch after write");
  dbg_write_a: assert property (dbg_flags_wr && !mem_rd && !mem_wr |=>
    dbg_flags_rdata == $past(dbg_flags_wdata))
    else $error("debug flag write lost");
endmodule
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        dbg_flags_wr = 1'b0;
  logic [1:0]  dbg_flags_wdata = 2'h0;
  wire  [13:0] mem_addr;
  wire         mem_rd;
  wire         mem_wr;
  wire  [7:0]  mem_wdata;
  wire  [7:0]  mem_rdata;
  wire  [1:0]  dbg_flags_rdata;
  wire  [7:0]  acc_value;
  wire  [13:0] pc_value;
  integer      num_errors = 0;
  integer      n_checks = 0;
  integer      seed = 34030;
  logic [7:0]  v, w, m, p, d1, d2, s, s2, x;
  logic [13:0] pc_w, l1, l2;
  logic [21:0] exp_wr [$];
  int          k;

  always #25 clock = ~clock;

  cpuag_core u_cpuag_core (.clock(clock), .rst(rst), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .dbg_flags_wr(dbg_flags_wr),
    .dbg_flags_wdata(dbg_flags_wdata), .dbg_flags_rdata(dbg_flags_rdata),
    .acc_value(acc_value), .pc_value(pc_value));
  cpuag_mem_model u_cpuag_mem_model (.clock(clock), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));

  task check(input string name, input logic [21:0] exp,
             input logic [21:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task complete_run;
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // bounded wait; the core never stalls, so 500 cycles is ample
  task wait_pc(input logic [13:0] a);
    int i;
    i = 0;
    while (pc_value !== a && i < 500) begin
      @(posedge clock);
      #1;
      i++;
    end
    if (i >= 500) begin
      check("pc wait", {8'h00, a}, {8'h00, pc_value});
      complete_run();
    end
  endtask

  task put(input logic [7:0] b);
    u_cpuag_mem_model.mem[pc_w] = b;
    pc_w++;
  endtask

  task do_reset;
    @(posedge clock);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
  endtask

  task dbg_write(input logic [1:0] d);
    @(posedge clock);
    dbg_flags_wr <= 1'b1;
    dbg_flags_wdata <= d;
    @(posedge clock);
    dbg_flags_wr <= 1'b0;
    #1;
  endtask

  initial begin
    v = $random(seed);
    w = $random(seed);
    m = $random(seed);
    p = 8'h40 | (8'h1F & $random(seed));
    d1 = 8'h20 | (8'h1F & $random(seed));
    d2 = 8'h80 | (8'h7F & $random(seed));
    s = 8'h10 | (8'h0F & $random(seed));
    s2 = 8'h10 | (8'h0F & $random(seed));
    x = 8'h07 & $random(seed);
    // junk in the top bits of the high byte must be ignored
    pc_w = 14'h3FFD;
    put(8'hBC); put(8'hC1); put(8'h00);
    pc_w = 14'h0100;
    put(8'hA6); put(v);
    put(8'hB7); put(d1); exp_wr.push_back({6'h00, d1, v});
    put(8'hE0 | s); exp_wr.push_back({6'h00, s, v});
    put(8'h3E); put(p); put(8'h0F);
    put(8'h3E); put(w); put(8'h0E); exp_wr.push_back({6'h00, p, w});
    put(8'h4E); put(d1); put(d2); exp_wr.push_back({6'h00, d2, v});
    put(8'hB6); put(8'h0E);
    put(8'h20 | x); u_cpuag_mem_model.mem[{6'h00, x}] = m;
    exp_wr.push_back({6'h00, x, m + 8'h01});
    put(8'h80 | s2); exp_wr.push_back({6'h00, s2, 8'h00});
    put(8'h63); put(8'h02); put(8'hA6); put(8'hAA);
    put(8'h61); put(8'h02); put(8'h39);
    l1 = pc_w;
    put(8'h62); put(8'hFE);
    l2 = pc_w;
    put(8'hBC); put({2'b00, l2[13:8]}); put(l2[7:0]);
    do_reset();
    wait_pc(l1);
    // pc reaches l1 while the set-borrow op still executes
    repeat (4) @(posedge clock);
    #1;
    check("acc", {14'h0, w}, {14'h0, acc_value});
    check("flags", 22'h3, {20'h0, dbg_flags_rdata});
    dbg_write(2'b01);
    check("dbg flags", 22'h1, {20'h0, dbg_flags_rdata});
    dbg_write(2'b10);
    wait_pc(l2);
    repeat (8) @(posedge clock);
    #1;
    check("flags after", 22'h2, {20'h0, dbg_flags_rdata});
    check("write count", exp_wr.size(),
          u_cpuag_mem_model.wr_log.size());
    for (k = 0; k < exp_wr.size(); k++)
      check("write", exp_wr[k], u_cpuag_mem_model.wr_log[k]);
    do_reset();
    #1;
    check("pc reset", 22'h3FFD, {8'h00, pc_value});
    check("acc reset", 22'h0, {14'h0, acc_value});
    check("flags reset", 22'h0, {20'h0, dbg_flags_rdata});
    complete_run();
  end
endmodule

bind cpuag_core cpuag_core_chk u_chk (.clock(clock), .rst(rst),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
  .dbg_flags_wr(dbg_flags_wr), .dbg_flags_wdata(dbg_flags_wdata),
  .dbg_flags_rdata(dbg_flags_rdata), .acc_value(acc_value),
  .pc_value(pc_value));
`default_nettype wire
